// *** rtl/sasq_pkg.sv ***
// Constants and types for the self-adjust and store sequencer
package sasq_pkg;

    // Core clock
    localparam int unsigned CLOCK_MHZ        = 200;
    localparam int unsigned CLOCK_PERIOD_PS  = 5000;

    // DAC code
    localparam int unsigned DAC_W            = 12;
    localparam logic [11:0] DAC_RESET        = 12'h000;
    localparam logic [11:0] DAC_MAX          = 12'hfff;
    localparam logic [11:0] DAC_ONE          = 12'h001;

    // Least trigger low time, rounded up to whole cycles
    localparam int unsigned TRIG_LOW_NS      = 100;
    localparam int unsigned TRIG_LOW_CYC     = (TRIG_LOW_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    localparam logic [4:0]  TRIG_LOW_LAST    = 5'(TRIG_LOW_CYC - 1);

    // One DAC step is one quantization size; the slowest settling rate
    // fixes the longest time one step may take, rounded down
    localparam int unsigned QUANT_UV         = 1500;
    localparam int unsigned SETTLE_MS_PER_V  = 10;
    localparam int unsigned STEP_NS          = SETTLE_MS_PER_V * QUANT_UV;
    localparam int unsigned STEP_CYC         = STEP_NS * 1000 / CLOCK_PERIOD_PS;
    localparam logic [11:0] STEP_LAST        = 12'(STEP_CYC - 1);

    // Nonvolatile write time, longest, rounded down
    localparam int unsigned NV_WRITE_MS      = 12;
    localparam int unsigned NV_WRITE_CYC     = int'(64'(NV_WRITE_MS) * 64'd1000000000 / 64'(CLOCK_PERIOD_PS));
    localparam int unsigned WR_CNT_W         = 22;

    // Turn-on time, longest, rounded down
    localparam int unsigned TURN_ON_US       = 10;
    localparam int unsigned TURN_ON_CYC      = TURN_ON_US * 1000000 / CLOCK_PERIOD_PS;

    typedef enum logic [1:0] {
        ST_RESTORE,
        ST_IDLE,
        ST_TRACK,
        ST_WRITE
    } sasq_state_t;

    typedef struct packed {
        sasq_state_t   state;
        logic          trig_meta;
        logic          trig_sync;
        logic          above_meta;
        logic          above_sync;
        logic          within_meta;
        logic          within_sync;
        logic          armed;
        logic [4:0]    low_cnt;
        logic [11:0]   step_cnt;
        logic [21:0]   wr_cnt;
        logic [11:0]   dac_code;
        logic [11:0]   nv_code;
        logic          nv_program;
        logic          tracking;
        logic          restored;
    } sasq_regs_t;

endpackage

// *** rtl/sasq_sequencer.sv ***
// Self-adjust and store sequencer: trigger qualify, DAC tracking, NV write, power-up restore
//
// Summary of operation
// - Self-adjust starts only after trigger stays low at least the trigger low time.
// - After the low time is met, the sequence runs on whatever trigger does.
// - Tracking begins once falling edge plus trigger low time has passed.
// - Tracking steps the DAC code toward the sample input until it is within the tracking window or at a rail.
// - Every DAC step moves the output by at most one quantization size.
// - Tracking time scales with output change, at most 10 ms per volt.
// - Within the tracking window the code is written to NV memory automatically.
// - The NV write phase lasts the write time, at most 12 ms.
// - Stored code survives power cycles and is reloaded into the DAC at power-up.
// - With trigger and sample open, restored output is valid within turn-on time.
// - Adjust and store may repeat any number of times, same order each time.
// - An open trigger reads inactive and the stored output is kept.
// - Trigger is level qualified; a low present at power-up also starts a cycle.
`timescale 1ns/1ps

module sasq_sequencer
    import sasq_pkg::*;
#(
    parameter int unsigned NV_WRITE_CYCLES = sasq_pkg::NV_WRITE_CYC
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        program_trigger_n,
    input  wire logic        sample_above,
    input  wire logic        sample_within,
    input  wire logic [11:0] nv_stored_code,
    output logic      [11:0] dac_code,
    output logic      [11:0] nv_code,
    output logic             nv_program,
    output logic             tracking,
    output logic             restored
);

    import sasq_pkg::*;

    localparam logic [21:0] WR_LAST = 22'(NV_WRITE_CYCLES - 1);

    sasq_regs_t r;
    sasq_regs_t next_r;

    logic at_limit;

    always_comb begin
        // Stepping past either end would wrap the code; treat a rail as done
        at_limit = (r.above_sync && (r.dac_code == DAC_MAX)) ||
                   (!r.above_sync && (r.dac_code == DAC_RESET));
    end

    always_comb begin
        next_r = r;
        // Trigger pin and comparator outputs come from outside the clock domain
        next_r.trig_meta   = program_trigger_n;
        next_r.trig_sync   = r.trig_meta;
        next_r.above_meta  = sample_above;
        next_r.above_sync  = r.above_meta;
        next_r.within_meta = sample_within;
        next_r.within_sync = r.within_meta;
        case (r.state)
            ST_RESTORE: begin
                next_r.dac_code = nv_stored_code;
                next_r.restored = 1'b1;
                next_r.state    = ST_IDLE;
            end
            ST_IDLE: begin
                if (r.trig_sync) begin
                    // Open trigger is pulled high and reads inactive
                    next_r.low_cnt = 5'h00;
                    next_r.armed   = 1'b1;
                end else if (r.armed) begin
                    if (r.low_cnt == TRIG_LOW_LAST) begin
                        next_r.state    = ST_TRACK;
                        next_r.tracking = 1'b1;
                        next_r.step_cnt = 12'h000;
                        next_r.low_cnt  = 5'h00;
                        next_r.armed    = 1'b0;
                    end else begin
                        next_r.low_cnt = r.low_cnt + 5'h01;
                    end
                end
            end
            ST_TRACK: begin
                // Trigger level is not looked at here
                if (r.step_cnt == STEP_LAST) begin
                    next_r.step_cnt = 12'h000;
                    if (r.within_sync || at_limit) begin
                        next_r.state      = ST_WRITE;
                        next_r.tracking   = 1'b0;
                        next_r.nv_program = 1'b1;
                        next_r.nv_code    = r.dac_code;
                        next_r.wr_cnt     = 22'h000000;
                    end else if (r.above_sync) begin
                        next_r.dac_code = r.dac_code + DAC_ONE;
                    end else begin
                        next_r.dac_code = r.dac_code - DAC_ONE;
                    end
                end else begin
                    next_r.step_cnt = r.step_cnt + 12'h001;
                end
            end
            ST_WRITE: begin
                // Code held fixed for the whole write so the NV cell sees one value
                if (r.wr_cnt == WR_LAST) begin
                    next_r.nv_program = 1'b0;
                    next_r.state      = ST_IDLE;
                    next_r.low_cnt    = 5'h00;
                end else begin
                    next_r.wr_cnt = r.wr_cnt + 22'h000001;
                end
            end
            default: begin
                next_r.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            r.state       <= ST_RESTORE;
            r.trig_meta   <= 1'b1;
            r.trig_sync   <= 1'b1;
            r.above_meta  <= 1'b0;
            r.above_sync  <= 1'b0;
            r.within_meta <= 1'b0;
            r.within_sync <= 1'b0;
            // Armed from power-up so a trigger already low is honoured
            r.armed       <= 1'b1;
            r.low_cnt     <= 5'h00;
            r.step_cnt    <= 12'h000;
            r.wr_cnt      <= 22'h000000;
            r.dac_code    <= DAC_RESET;
            r.nv_code     <= DAC_RESET;
            r.nv_program  <= 1'b0;
            r.tracking    <= 1'b0;
            r.restored    <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    always_comb begin
        dac_code   = r.dac_code;
        nv_code    = r.nv_code;
        nv_program = r.nv_program;
        tracking   = r.tracking;
        restored   = r.restored;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    property p_trig_qualified;
        $rose(r.tracking) |-> $past(r.low_cnt) == TRIG_LOW_LAST && !$past(r.trig_sync) && $past(r.armed);
    endproperty
    a_trig_qualified: assert property (p_trig_qualified)
        else $error("Tracking began without a qualified trigger low");

    property p_no_abort;
        r.tracking |=> r.tracking || (r.nv_program && $rose(r.nv_program));
    endproperty
    a_no_abort: assert property (p_no_abort)
        else $error("Tracking ended without entering the write phase");

    property p_track_start;
        (r.state == ST_IDLE) && r.armed && !r.trig_sync && (r.low_cnt == TRIG_LOW_LAST)
            |=> r.tracking && (r.step_cnt == 12'h000);
    endproperty
    a_track_start: assert property (p_track_start)
        else $error("Tracking did not start after the trigger low time");

    property p_single_step;
        r.tracking && (r.step_cnt == STEP_LAST) && !r.within_sync && !at_limit
            |=> (r.dac_code == $past(r.dac_code) + ($past(r.above_sync) ? DAC_ONE : DAC_MAX));
    endproperty
    a_single_step: assert property (p_single_step)
        else $error("DAC step was not one code toward the sample");

    property p_step_rate;
        r.tracking && $changed(r.dac_code) |-> $past(r.step_cnt) == STEP_LAST;
    endproperty
    a_step_rate: assert property (p_step_rate)
        else $error("DAC code changed before the step interval elapsed");

    property p_auto_store;
        r.tracking && r.within_sync && (r.step_cnt == STEP_LAST)
            |=> r.nv_program && !r.tracking && (r.nv_code == $past(r.dac_code));
    endproperty
    a_auto_store: assert property (p_auto_store)
        else $error("Write did not start with the tracked code");

    property p_write_length;
        $fell(r.nv_program) |-> $past(r.wr_cnt) == WR_LAST;
    endproperty
    a_write_length: assert property (p_write_length)
        else $error("Write phase length differs from the write time");

    property p_restore;
        !r.restored |=> r.restored && (r.dac_code == $past(nv_stored_code)) ##1 r.restored [*3];
    endproperty
    a_restore: assert property (p_restore)
        else $error("Stored code not reloaded at power-up");

    property p_ignore_busy;
        r.nv_program && !r.trig_sync |=> !r.tracking;
    endproperty
    a_ignore_busy: assert property (p_ignore_busy)
        else $error("Trigger accepted while writing");

    property p_code_stable;
        r.nv_program && $past(r.nv_program) |-> $stable(r.nv_code);
    endproperty
    a_code_stable: assert property (p_code_stable)
        else $error("Write data changed during the write phase");

    property p_cover_track;
        $rose(r.tracking);
    endproperty
    c_cover_track: cover property (p_cover_track);

    property p_cover_store_done;
        $fell(r.nv_program);
    endproperty
    c_cover_store_done: cover property (p_cover_store_done);

    property p_cover_rail;
        r.tracking && at_limit && (r.step_cnt == STEP_LAST);
    endproperty
    c_cover_rail: cover property (p_cover_rail);

endmodule

// *** sim/sasq_fixture_model.sv ***
// Fixture side: analog tracking comparators and the NV cell
`timescale 1ns/1ps

module sasq_fixture_model
    import sasq_pkg::*;
#(
    parameter int unsigned WIN_CODES = 13,
    parameter logic [11:0] NV_INIT   = 12'h100
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [11:0] target,
    input  wire logic [11:0] dac_code,
    input  wire logic [11:0] nv_code,
    input  wire logic        nv_program,
    output logic             sample_above,
    output logic             sample_within,
    output logic      [11:0] nv_stored_code
);
    logic prog_q;

    // Target is held by the bench for the whole procedure
    always_comb begin
        sample_above  = target > dac_code;
        sample_within = (target > dac_code) ? (target - dac_code <= WIN_CODES)
                                            : (dac_code - target <= WIN_CODES);
    end

    initial nv_stored_code = NV_INIT;

    // Commit only on a write that ran to its end; a reset cut keeps the old code
    always @(posedge clock) begin
        prog_q <= nv_program;
        if (prog_q && !nv_program && !sys_rst) begin
            nv_stored_code <= nv_code;
        end
    end
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the self-adjust and store sequencer
`timescale 1ns/1ps

module testbench;
    import sasq_pkg::*;
    localparam int unsigned W = 13;
    localparam int unsigned NWR = 50;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        program_trigger_n = 1'b1;
    logic [11:0] target = 12'h100;
    logic        sample_above;
    logic        sample_within;
    logic [11:0] nv_stored_code;
    logic [11:0] dac_code;
    logic [11:0] nv_code;
    logic [11:0] prev;
    logic        nv_program;
    logic        tracking;
    logic        restored;
    int          n_errors = 0;
    int          total_checks = 0;
    int          seed;

    always #2.5 clock = ~clock;

    sasq_sequencer #(.NV_WRITE_CYCLES(NWR)) u_dut (.clock(clock), .sys_rst(sys_rst),
        .program_trigger_n(program_trigger_n), .sample_above(sample_above), .sample_within(sample_within),
        .nv_stored_code(nv_stored_code), .dac_code(dac_code), .nv_code(nv_code), .nv_program(nv_program),
        .tracking(tracking), .restored(restored));
    sasq_fixture_model #(.WIN_CODES(W)) u_fix (.clock(clock), .sys_rst(sys_rst), .target(target),
        .dac_code(dac_code), .nv_code(nv_code), .nv_program(nv_program), .sample_above(sample_above),
        .sample_within(sample_within), .nv_stored_code(nv_stored_code));

    task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic do_reset();
        sys_rst = 1'b1;
        tick(4);
        sys_rst = 1'b0;
        tick(1);
        check(restored, 1'b1, "restore flag");
        check(dac_code, nv_stored_code, "restored code");
    endtask

    // Waits for a level on a design output; returns cycles taken
    task automatic wait_for(ref logic sig, input logic lvl, input int lim, output int n);
        n = 0;
        while (sig !== lvl && n < lim) begin
            tick(1);
            n++;
        end
    endtask

    function automatic logic [11:0] final_code(input logic [11:0] t, input bit up);
        return up ? t - 12'(W) : t + 12'(W);
    endfunction

    // Step monitor: each change while tracking is one code
    always @(posedge clock) begin
        prev <= dac_code;
        if (!sys_rst && tracking === 1'b1 && dac_code !== prev) begin
            check(12'(dac_code - prev + 12'h001) <= 12'h002, 1'b1, "step size");
        end
    end

    task automatic adjust(input int k, input bit up, input bit cut);
        logic [11:0] s;
        logic [11:0] e;
        int n;
        s = dac_code;
        target = up ? s + 12'(W + k) : s - 12'(W + k);
        e = final_code(target, up);
        program_trigger_n = 1'b0;
        wait_for(tracking, 1'b1, 30, n);
        check(n >= 20 && n <= 24, 1'b1, "tracking start");
        tick(3);
        program_trigger_n = 1'b1;
        tick(40);
        program_trigger_n = 1'b0;
        tick(25);
        program_trigger_n = 1'b1;
        check(tracking, 1'b1, "retrigger ignored");
        wait_for(nv_program, 1'b1, (k + 2) * 3000, n);
        check(n < (k + 2) * 3000, 1'b1, "tracking time");
        check(tracking, 1'b0, "tracking end");
        check(nv_code, e, "stored code");
        check(dac_code, e, "final code");
        if (cut) begin
            tick(10);
            do_reset();
            check(dac_code, s, "cut write keeps old");
        end else begin
            wait_for(nv_program, 1'b0, NWR + 5, n);
            check(n == NWR, 1'b1, "write time");
            // Supply stays up until the cell has taken the code
            tick(2);
            do_reset();
            check(dac_code, e, "reload");
        end
        $display("adjust run k=%0d up=%0d cut=%0d done", k, up, cut);
    endtask

    initial begin
        int n;
        seed = $urandom(32'h8321);
        do_reset();
        program_trigger_n = 1'b0;
        tick(10);
        program_trigger_n = 1'b1;
        tick(30);
        check(tracking, 1'b0, "short pulse");
        $display("short pulse test done");
        adjust(3, 1'b1, 1'b0);
        adjust($urandom_range(1, 3), 1'b0, 1'b0);
        adjust($urandom_range(1, 3), 1'b1, 1'b1);
        adjust($urandom_range(1, 3), 1'($urandom_range(0, 1)), 1'b0);
        target = dac_code;
        program_trigger_n = 1'b0;
        do_reset();
        wait_for(tracking, 1'b1, 30, n);
        check(tracking, 1'b1, "low at power-up");
        program_trigger_n = 1'b1;
        wait_for(nv_program, 1'b1, 7000, n);
        wait_for(nv_program, 1'b0, NWR + 5, n);
        tick(2);
        check(nv_stored_code, target, "same code kept");
        $display("power-up trigger test done");
        complete_run();
    end

    initial begin
        #500000;
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end
endmodule
